// *** hw/sgfac_pkg.sv ***
// Constants for the global frame and aging control bank
`default_nettype none
package sgfac_pkg;
    localparam logic [7:0] ADDR_GLOBAL_CONTROL_ZERO = 8'h02;
    localparam logic [7:0] ADDR_GLOBAL_CONTROL_ONE = 8'h03;
    // global_control_zero fields
    localparam int BIT_PAUSE_FILTER = 1;
    localparam int BIT_LINK_CHANGE_AGE = 0;
    // global_control_one fields
    localparam int BIT_PASS_ALL = 7;
    localparam int BIT_TX_FC_DIS = 5;
    localparam int BIT_RX_FC_DIS = 4;
    localparam int BIT_LEN_CHECK = 3;
    localparam int BIT_AGING_EN = 2;
    // Writable masks; other bits hold their reset value
    localparam logic [7:0] MASK_ZERO = 8'h03;
    localparam logic [7:0] MASK_ONE = 8'hbc;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    // Frame matching constants
    localparam logic [15:0] PAUSE_TYPE = 16'h8808;
    localparam logic [47:0] PAUSE_DA = 48'h0180_c200_0001;
    localparam logic [15:0] MAX_LEN_CHECK = 16'h05dc;
    // Timing
    localparam int CLOCK_HZ = 10_000_000;
    localparam int FAST_AGE_US = 800;
    localparam int FAST_AGE_CYCLES = FAST_AGE_US * (CLOCK_HZ / 1_000_000);
    localparam int NORMAL_AGE_S = 300;
    localparam int NORMAL_AGE_JITTER_S = 75;
    localparam int NORMAL_AGE_TOTAL_S = NORMAL_AGE_S + NORMAL_AGE_JITTER_S;
endpackage
`default_nettype wire

// *** hw/sgfac_ctrl.sv ***
// Global frame filter, flow control and address aging control bank
// Notes on behaviour
// - With pause filtering on, frames of type 0x8808 or to 01-80-C2-00-00-01 are dropped.
// - With pause filtering off, only genuine flow control frames are dropped as pause frames.
// - With link-change aging on, a port going down outside a fast pass starts one fast aging pass lasting 800 us.
// - After the fast pass the aging logic goes back to its normal period of 300 plus 75 seconds.
// - With link-change aging on, any port losing link outside a fast pass ages out every learned address.
// - Pass-all mode forwards every frame, errored ones too, for debug with mirroring.
// - Transmit flow control disable at zero lets the autonegotiation result enable it.
// - Receive flow control disable at zero follows autonegotiation, at one keeps it off.
// - Both flow control disable bits reset from one shared strap, then are written separately.
// - Length checking drops IEEE frames below 1500 whose length field mismatches the real length.
// - Aging enable turns normal aging on or off and resets from a strap pulled up by default.
//
// The strobed register port was chosen for this implementation.
`default_nettype none
module sgfac_ctrl #(
    parameter int NUM_PORTS = 5,
    parameter int FAST_AGE_LEN = sgfac_pkg::FAST_AGE_CYCLES,
    parameter int NORMAL_TICKS_PER_S = sgfac_pkg::CLOCK_HZ
) (
    input wire logic clock,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Straps
    input wire logic flow_ctrl_strap_pin,
    input wire logic aging_strap_pin,
    // Receive frame classification, one-cycle strobe per frame end
    input wire logic rx_frame_valid,
    input wire logic [47:0] rx_dest_addr,
    input wire logic [15:0] rx_type_len,
    input wire logic [15:0] rx_actual_len,
    input wire logic rx_frame_error,
    input wire logic rx_is_flow_ctrl,
    output logic rx_drop_q,
    output logic rx_forward_q,
    // Flow control
    input wire logic [NUM_PORTS-1:0] an_tx_pause,
    input wire logic [NUM_PORTS-1:0] an_rx_pause,
    output logic [NUM_PORTS-1:0] tx_fc_en_q,
    output logic [NUM_PORTS-1:0] rx_fc_en_q,
    // Aging
    input wire logic [NUM_PORTS-1:0] port_link_up,
    output logic age_enable,
    output logic fast_age_active,
    output logic flush_all_q,
    output logic normal_age_tick_q,
    output logic pass_all_mode
);
    import sgfac_pkg::*;

    typedef enum logic [1:0] {SGFAC_NORMAL, SGFAC_FAST} sgfac_age_e;

    logic [7:0] ctrl_zero_q;
    logic [7:0] ctrl_one_q;
    logic strap_done_q;
    logic [NUM_PORTS-1:0] link_q;
    logic link_lost;
    sgfac_age_e age_state_q;
    logic [31:0] fast_cnt_q;
    logic [31:0] sec_cnt_q;
    logic [31:0] tick_cnt_q;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_zero_q <= RESET_ZERO;
            ctrl_one_q <= 8'h00;
            strap_done_q <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            strap_done_q <= 1'b1;
            ctrl_one_q[BIT_TX_FC_DIS] <= flow_ctrl_strap_pin;
            ctrl_one_q[BIT_RX_FC_DIS] <= flow_ctrl_strap_pin;
            ctrl_one_q[BIT_AGING_EN] <= aging_strap_pin;
        end
        else if (reg_write)
        begin
            if (reg_addr == ADDR_GLOBAL_CONTROL_ZERO)
                ctrl_zero_q <= reg_wdata & MASK_ZERO;
            if (reg_addr == ADDR_GLOBAL_CONTROL_ONE)
                ctrl_one_q <= reg_wdata & MASK_ONE;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (reg_read && reg_addr == ADDR_GLOBAL_CONTROL_ZERO)
            reg_rdata <= ctrl_zero_q;
        else if (reg_read && reg_addr == ADDR_GLOBAL_CONTROL_ONE)
            reg_rdata <= ctrl_one_q;
        else
            reg_rdata <= 8'h00;
    end

    assign pass_all_mode = ctrl_one_q[BIT_PASS_ALL];
    assign age_enable = ctrl_one_q[BIT_AGING_EN];

    // ----------------------------------------
    // Receive filter
    // ----------------------------------------
    function automatic logic frame_dropped(input logic pause_filt, input logic len_chk);
        logic pause_hit;
        logic len_bad;
        pause_hit = pause_filt ? (rx_type_len == PAUSE_TYPE || rx_dest_addr == PAUSE_DA)
                               : rx_is_flow_ctrl;
        len_bad = len_chk && rx_type_len < MAX_LEN_CHECK && rx_type_len != rx_actual_len;
        frame_dropped = pause_hit || len_bad || rx_frame_error;
    endfunction

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_drop_q <= 1'b0;
            rx_forward_q <= 1'b0;
        end
        else
        begin
            if (rx_frame_valid && ctrl_one_q[BIT_PASS_ALL])
            begin
                rx_drop_q <= 1'b0;
                rx_forward_q <= 1'b1;
            end
            else
            begin
                rx_drop_q <= rx_frame_valid && frame_dropped(ctrl_zero_q[BIT_PAUSE_FILTER],
                                                             ctrl_one_q[BIT_LEN_CHECK]);
                rx_forward_q <= rx_frame_valid && !frame_dropped(ctrl_zero_q[BIT_PAUSE_FILTER],
                                                                 ctrl_one_q[BIT_LEN_CHECK]);
            end
        end
    end

    // ----------------------------------------
    // Flow control enables
    // ----------------------------------------
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_fc_en_q <= '0;
            rx_fc_en_q <= '0;
        end
        else
        begin
            tx_fc_en_q <= ctrl_one_q[BIT_TX_FC_DIS] ? '0 : an_tx_pause;
            rx_fc_en_q <= ctrl_one_q[BIT_RX_FC_DIS] ? '0 : an_rx_pause;
        end
    end

    // ----------------------------------------
    // Aging engine
    // ----------------------------------------
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            link_q <= '0;
        else
            link_q <= port_link_up;
    end

    assign link_lost = |(link_q & ~port_link_up);
    assign fast_age_active = (age_state_q == SGFAC_FAST);

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            age_state_q <= SGFAC_NORMAL;
            fast_cnt_q <= 32'h0000_0000;
            flush_all_q <= 1'b0;
        end
        else
        begin
            flush_all_q <= 1'b0;
            case (age_state_q)
                SGFAC_NORMAL:
                begin
                    if (link_lost && ctrl_zero_q[BIT_LINK_CHANGE_AGE])
                    begin
                        age_state_q <= SGFAC_FAST;
                        flush_all_q <= 1'b1;
                        fast_cnt_q <= 32'h0000_0000;
                    end
                end
                SGFAC_FAST:
                begin
                    if (fast_cnt_q >= 32'(FAST_AGE_LEN - 1))
                        age_state_q <= SGFAC_NORMAL;
                    else
                        fast_cnt_q <= fast_cnt_q + 32'h0000_0001;
                end
                default:
                    age_state_q <= SGFAC_NORMAL;
            endcase
        end
    end

    // Normal aging tick every NORMAL_AGE_TOTAL_S seconds
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt_q <= 32'h0000_0000;
            sec_cnt_q <= 32'h0000_0000;
            normal_age_tick_q <= 1'b0;
        end
        else
        begin
            normal_age_tick_q <= 1'b0;
            if (!age_enable || fast_age_active)
            begin
                tick_cnt_q <= 32'h0000_0000;
                sec_cnt_q <= 32'h0000_0000;
            end
            else if (tick_cnt_q == 32'(NORMAL_TICKS_PER_S - 1))
            begin
                tick_cnt_q <= 32'h0000_0000;
                if (sec_cnt_q == 32'(NORMAL_AGE_TOTAL_S - 1))
                begin
                    sec_cnt_q <= 32'h0000_0000;
                    normal_age_tick_q <= 1'b1;
                end
                else
                    sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
            end
            else
                tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// *** verif/sgfac_chk.sv ***
// Port assertions for the global frame and aging control bank
`default_nettype none
module sgfac_chk #(
    parameter int NP = 5,
    parameter int FL = 10
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic rx_frame_valid,
    input wire logic rx_drop_q,
    input wire logic rx_forward_q,
    input wire logic pass_all_mode,
    input wire logic [NP-1:0] an_tx_pause,
    input wire logic [NP-1:0] tx_fc_en_q,
    input wire logic fast_age_active,
    input wire logic flush_all_q,
    input wire logic normal_age_tick_q,
    input wire logic age_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FL1 = FL - 1;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);
    a_resp_onehot: assert property (rx_frame_valid |=> rx_drop_q != rx_forward_q)
        else $error("frame answer not one-hot");
    a_resp_idle: assert property (!rx_frame_valid |=> !rx_drop_q && !rx_forward_q)
        else $error("frame answer without frame");
    a_pass_fwd: assert property (rx_frame_valid && pass_all_mode |=> rx_forward_q)
        else $error("pass-all frame not forwarded");
    a_tx_fc_gate: assert property ((tx_fc_en_q & ~$past(an_tx_pause)) == '0)
        else $error("tx flow control beyond negotiation");
    a_flush_start: assert property ($rose(fast_age_active) |-> flush_all_q)
        else $error("fast pass without flush");
    a_fast_len: assert property ($rose(fast_age_active) |-> ##FL1 fast_age_active ##1 !fast_age_active)
        else $error("fast pass length wrong");
    a_flush_pulse: assert property (flush_all_q |-> fast_age_active ##1 !flush_all_q)
        else $error("flush pulse wrong");
    a_tick_quiet: assert property ((fast_age_active || !age_enable) && ($past(fast_age_active)
        || !$past(age_enable)) |-> !normal_age_tick_q)
        else $error("aging tick while off or fast");
    c_fast: cover property ($rose(fast_age_active));
    c_pass: cover property (rx_frame_valid && pass_all_mode);
    c_tick: cover property (normal_age_tick_q);
endmodule
bind sgfac_ctrl sgfac_chk #(.NP(NUM_PORTS), .FL(FAST_AGE_LEN)) u_chk (.clock(clock), .nrst(nrst),
    .rx_frame_valid(rx_frame_valid), .rx_drop_q(rx_drop_q), .rx_forward_q(rx_forward_q),
    .pass_all_mode(pass_all_mode), .an_tx_pause(an_tx_pause), .tx_fc_en_q(tx_fc_en_q),
    .fast_age_active(fast_age_active), .flush_all_q(flush_all_q), .normal_age_tick_q(normal_age_tick_q),
    .age_enable(age_enable));
`default_nettype wire

// *** verif/sgfac_test.sv ***
// Self-checking bench for the global frame and aging control bank
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module switch_global_frame_and_aging_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sgfac_pkg::*;
    localparam int TPS = 4;
    logic clock = 0, nrst = 0, reg_write = 0, reg_read = 0, rx_frame_valid = 0, rx_frame_error = 0;
    logic rx_is_flow_ctrl = 0, rx_drop_q, rx_forward_q, age_enable, fast_age_active, flush_all_q;
    logic normal_age_tick_q, pass_all_mode;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [47:0] rx_dest_addr = 0;
    logic [15:0] rx_type_len = 0, rx_actual_len = 0;
    logic [4:0] an_tx_pause = 5'h15, an_rx_pause = 5'h0a, port_link_up = 5'h1f, tx_fc_en_q, rx_fc_en_q;
    logic fc_strap = 1, ag_strap = 1;
    int failures = 0, n_checks = 0, n;
    sgfac_ctrl #(.FAST_AGE_LEN(10), .NORMAL_TICKS_PER_S(TPS)) uut (.clock(clock), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .flow_ctrl_strap_pin(fc_strap), .aging_strap_pin(ag_strap),
        .rx_frame_valid(rx_frame_valid), .rx_dest_addr(rx_dest_addr), .rx_type_len(rx_type_len),
        .rx_actual_len(rx_actual_len), .rx_frame_error(rx_frame_error), .rx_is_flow_ctrl(rx_is_flow_ctrl),
        .rx_drop_q(rx_drop_q), .rx_forward_q(rx_forward_q), .an_tx_pause(an_tx_pause),
        .an_rx_pause(an_rx_pause), .tx_fc_en_q(tx_fc_en_q), .rx_fc_en_q(rx_fc_en_q),
        .port_link_up(port_link_up), .age_enable(age_enable), .fast_age_active(fast_age_active),
        .flush_all_q(flush_all_q), .normal_age_tick_q(normal_age_tick_q), .pass_all_mode(pass_all_mode));
    initial
    begin
        forever #50 clock = ~clock;
    end
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic lim(input int k, input int m);
        if (k >= m)
        begin
            failures++;
            final_report;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clock);
        reg_write <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clock);
        reg_read <= 1'h0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask
    task automatic fr(input logic [47:0] da, input logic [15:0] tl, al, input logic er, fc, dr);
        @(posedge clock);
        {rx_dest_addr, rx_type_len, rx_actual_len, rx_frame_error, rx_is_flow_ctrl} <= {da, tl, al, er, fc};
        rx_frame_valid <= 1'h1;
        @(posedge clock);
        rx_frame_valid <= 1'h0;
        #1;
        `CHK("rx_drop_q", dr, rx_drop_q)
        `CHK("rx_forward_q", !dr, rx_forward_q)
    endtask
    initial
    begin
        repeat (8) @(posedge clock);
        nrst <= 1'h1;
        repeat (2) @(posedge clock);
        rd(ADDR_GLOBAL_CONTROL_ZERO, RESET_ZERO);
        rd(ADDR_GLOBAL_CONTROL_ONE, 8'h34);
        rd(8'h05, 8'h00);
        `CHK("tx_fc_en_q", 5'h00, tx_fc_en_q)
        wr(ADDR_GLOBAL_CONTROL_ONE, 8'h10);
        rd(ADDR_GLOBAL_CONTROL_ONE, 8'h10);
        `CHK("tx_fc_en_q", 5'h15, tx_fc_en_q)
        `CHK("rx_fc_en_q", 5'h00, rx_fc_en_q)
        wr(ADDR_GLOBAL_CONTROL_ONE, 8'h20);
        rd(ADDR_GLOBAL_CONTROL_ONE, 8'h20);
        `CHK("tx_fc_en_q", 5'h00, tx_fc_en_q)
        `CHK("rx_fc_en_q", 5'h0a, rx_fc_en_q)
        wr(ADDR_GLOBAL_CONTROL_ONE, 8'hff);
        rd(ADDR_GLOBAL_CONTROL_ONE, MASK_ONE);
        `CHK("pass_all_mode", 1'h1, pass_all_mode)
        fr(48'h0, PAUSE_TYPE, 16'h0040, 1'h1, 1'h1, 1'h0);
        wr(ADDR_GLOBAL_CONTROL_ONE, 8'h08);
        wr(ADDR_GLOBAL_CONTROL_ZERO, 8'h02);
        fr(48'h0, PAUSE_TYPE, 16'h0040, 1'h0, 1'h0, 1'h1);
        fr(PAUSE_DA, 16'h0800, 16'h0040, 1'h0, 1'h0, 1'h1);
        fr(48'h0, 16'h0800, 16'h0040, 1'h0, 1'h1, 1'h0);
        fr(48'h0, 16'h05db, 16'h05da, 1'h0, 1'h0, 1'h1);
        fr(48'h0, MAX_LEN_CHECK, 16'h0040, 1'h0, 1'h0, 1'h0);
        wr(ADDR_GLOBAL_CONTROL_ZERO, 8'h00);
        fr(48'h0, PAUSE_TYPE, 16'h0040, 1'h0, 1'h0, 1'h0);
        fr(48'h0, 16'h0800, 16'h0040, 1'h0, 1'h1, 1'h1);
        $display("filter test done");
        wr(ADDR_GLOBAL_CONTROL_ONE, 8'h04);
        wr(ADDR_GLOBAL_CONTROL_ZERO, 8'h01);
        @(posedge clock) port_link_up <= 5'h1b;
        for (n = 0; n < 5 && flush_all_q !== 1'h1; n++) @(posedge clock) #1;
        lim(n, 5);
        for (n = 0; n < 50 && fast_age_active === 1'h1; n++) @(posedge clock) #1;
        `CHK("fast_len", 10, n)
        for (n = 0; n < 2000 && normal_age_tick_q !== 1'h1; n++) @(posedge clock) #1;
        lim(n, 2000);
        n = 0;
        do begin @(posedge clock) #1; n++; end while (normal_age_tick_q !== 1'h1 && n < 2000);
        `CHK("tick_period", NORMAL_AGE_TOTAL_S * TPS, n)
        @(posedge clock) port_link_up <= 5'h1f;
        wr(ADDR_GLOBAL_CONTROL_ZERO, 8'h00);
        wr(ADDR_GLOBAL_CONTROL_ONE, 8'h00);
        #1;
        `CHK("age_enable", 1'h0, age_enable)
        port_link_up <= 5'h17;
        n = 0;
        for (int k = 0; k < 1600; k++) begin @(posedge clock) #1; n += normal_age_tick_q + flush_all_q; end
        `CHK("tick_or_flush", 0, n)
        $display("aging test done");
        @(posedge clock);
        nrst <= 1'h0;
        fc_strap <= 1'h0;
        ag_strap <= 1'h0;
        repeat (8) @(posedge clock);
        nrst <= 1'h1;
        repeat (2) @(posedge clock);
        rd(ADDR_GLOBAL_CONTROL_ONE, 8'h00);
        `CHK("tx_fc_en_q", 5'h15, tx_fc_en_q)
        `CHK("age_enable", 1'h0, age_enable)
        $display("strap test done");
        final_report;
    end
endmodule
`default_nettype wire
